// *** hw/dtp_chan_if.sv ***
`timescale 1ns/10ps
// one timer channel: controls in, events and state out
interface dtp_chan_if #(
  parameter int W = 16
);
  logic         run;
  logic         clk_sel;
  logic         pre_tick;
  logic [W-1:0] match_val;
  logic         match_pulse;
  logic         toggle;
  logic [W-1:0] count;

  modport ctrl (
    output run, clk_sel, pre_tick, match_val,
    input  match_pulse, toggle, count
  );
  modport chan (
    input  run, clk_sel, pre_tick, match_val,
    output match_pulse, toggle, count
  );
endinterface

// *** hw/dtp_dual_timer.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module dtp_dual_timer
  import dtp_pkg::*;
#(
  parameter int CNT_W = DTP_CNT_W,
  parameter int PRE_W = DTP_PRE_W
)
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] bus_addr_i,
  input  wire logic [15:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_word_i,
  output logic      [15:0] bus_rdata_o,
  input  wire logic        first_osc_i,
  input  wire logic        second_osc_i,
  output logic             timer_a_toggle_out_o,
  output logic             timer_b_toggle_out_o,
  output logic             timer_a_irq_o,
  output logic             timer_b_irq_o,
  output logic             irq_o,
  output logic      [15:0] irq_vector_o
);

  localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);
  localparam logic [PRE_W-1:0] PRE_ZERO = PRE_W'(0);

  // software registers
  logic [7:0] a_low_r;
  logic [7:0] a_high_r;
  logic [7:0] b_low_r;
  logic [7:0] b_high_r;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] clkset_r;
  logic [15:0] rdata_r;
  logic        irq_a_r;
  logic        irq_b_r;
  logic        irq_r;
  logic [15:0] vec_r;

  // oscillator synchronisers and edge detect
  logic [1:0] first_oscillator_sync_r;
  logic [1:0] second_oscillator_sync_r;
  logic       first_oscillator_prev_r;
  logic       second_oscillator_prev_r;
  logic       first_oscillator_edge_w;
  logic       second_oscillator_edge_w;

  // prescaler
  logic [PRE_W-1:0] pre_cnt_r;
  logic [PRE_W-1:0] pre_period_w;
  dtp_src_t         pre_src_w;
  logic             pre_run_w;
  logic             pre_en_w;
  logic             pre_tick_w;

  // bus decode
  logic [15:0] addr_inc_w;
  logic        we_a_lo_w;
  logic        we_a_hi_w;
  logic        we_b_lo_w;
  logic        we_b_hi_w;
  logic        we_ctrl_w;
  logic        we_clk_w;
  logic        we_iclr_w;
  logic        we_ien_w;
  logic [7:0]  wd_ctrl_w;
  logic [7:0]  wd_iclr_w;
  logic [7:0]  wd_ien_w;
  logic [7:0]  rd_lo_w;
  logic [7:0]  rd_hi_w;
  logic        flag_a_w;
  logic        flag_b_w;
  logic        pend_a_w;
  logic        pend_b_w;

  dtp_chan_if #(.W(CNT_W)) ch_a ();
  dtp_chan_if #(.W(CNT_W)) ch_b ();

  // a byte register is hit by its own address or as the upper half of
  // a word access starting one below it
  function automatic logic byte_hit(input logic [15:0] reg_addr);
    byte_hit = (bus_addr_i == reg_addr)
             | (bus_word_i & (addr_inc_w == reg_addr));
  endfunction

  function automatic logic [7:0] byte_data(input logic [15:0] reg_addr);
    byte_data = (bus_addr_i == reg_addr) ? bus_wdata_i[7:0]
                                         : bus_wdata_i[15:8];
  endfunction

  // read mux; clear register is write-only and reads zero
  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    logic [7:0] v;
    v = DTP_BYTE_RST;
    if (a == DTP_ADDR_A_LOW)  v = a_low_r;
    if (a == DTP_ADDR_A_HIGH) v = a_high_r;
    if (a == DTP_ADDR_B_LOW)  v = b_low_r;
    if (a == DTP_ADDR_B_HIGH) v = b_high_r;
    if (a == DTP_ADDR_CTRL)   v = ctrl_r;
    if (a == DTP_ADDR_CLKSET) v = clkset_r;
    if (a == DTP_ADDR_ISTAT)
    begin
      v[DTP_IRQ_A] = ctrl_r[DTP_A_FLG];
      v[DTP_IRQ_B] = ctrl_r[DTP_B_FLG];
    end
    if (a == DTP_ADDR_IEN)
    begin
      v[DTP_IRQ_A] = ctrl_r[DTP_A_IE];
      v[DTP_IRQ_B] = ctrl_r[DTP_B_IE];
    end
    rd_byte = v;
  endfunction

  // write strobes per byte register, word access covers two bytes
  assign addr_inc_w = bus_addr_i + DTP_ADDR_STEP;
  assign we_a_lo_w  = bus_wr_i & byte_hit(DTP_ADDR_A_LOW);
  assign we_a_hi_w  = bus_wr_i & byte_hit(DTP_ADDR_A_HIGH);
  assign we_b_lo_w  = bus_wr_i & byte_hit(DTP_ADDR_B_LOW);
  assign we_b_hi_w  = bus_wr_i & byte_hit(DTP_ADDR_B_HIGH);
  assign we_ctrl_w  = bus_wr_i & byte_hit(DTP_ADDR_CTRL);
  assign we_clk_w   = bus_wr_i & byte_hit(DTP_ADDR_CLKSET);
  assign we_iclr_w  = bus_wr_i & byte_hit(DTP_ADDR_ICLR);
  assign we_ien_w   = bus_wr_i & byte_hit(DTP_ADDR_IEN);
  assign wd_ctrl_w  = byte_data(DTP_ADDR_CTRL);
  assign wd_iclr_w  = byte_data(DTP_ADDR_ICLR);
  assign wd_ien_w   = byte_data(DTP_ADDR_IEN);
  assign rd_lo_w    = rd_byte(bus_addr_i);
  assign rd_hi_w    = bus_word_i ? rd_byte(addr_inc_w) : DTP_BYTE_RST;

  // control next value: flags only clear by software, set wins
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (we_ctrl_w)
    begin
      ctrl_nxt = wd_ctrl_w;
      ctrl_nxt[DTP_A_FLG] = ctrl_r[DTP_A_FLG]
                          & wd_ctrl_w[DTP_A_FLG];
      ctrl_nxt[DTP_B_FLG] = ctrl_r[DTP_B_FLG]
                          & wd_ctrl_w[DTP_B_FLG];
    end
    if (we_iclr_w && wd_iclr_w[DTP_IRQ_A])
      ctrl_nxt[DTP_A_FLG] = 1'b0;
    if (we_iclr_w && wd_iclr_w[DTP_IRQ_B])
      ctrl_nxt[DTP_B_FLG] = 1'b0;
    if (we_ien_w)
    begin
      ctrl_nxt[DTP_A_IE] = wd_ien_w[DTP_IRQ_A];
      ctrl_nxt[DTP_B_IE] = wd_ien_w[DTP_IRQ_B];
    end
    if (ch_a.match_pulse)
      ctrl_nxt[DTP_A_FLG] = 1'b1;
    if (ch_b.match_pulse)
      ctrl_nxt[DTP_B_FLG] = 1'b1;
  end

  // register file storage
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      a_low_r  <= DTP_BYTE_RST;
      a_high_r <= DTP_BYTE_RST;
      b_low_r  <= DTP_BYTE_RST;
      b_high_r <= DTP_BYTE_RST;
      ctrl_r   <= DTP_BYTE_RST;
      clkset_r <= DTP_BYTE_RST;
    end
    else
    begin
      if (we_a_lo_w) a_low_r  <= byte_data(DTP_ADDR_A_LOW);
      if (we_a_hi_w) a_high_r <= byte_data(DTP_ADDR_A_HIGH);
      if (we_b_lo_w) b_low_r  <= byte_data(DTP_ADDR_B_LOW);
      if (we_b_hi_w) b_high_r <= byte_data(DTP_ADDR_B_HIGH);
      if (we_clk_w)  clkset_r <= byte_data(DTP_ADDR_CLKSET);
      ctrl_r <= ctrl_nxt;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !bus_rd_i)
      rdata_r <= DTP_WORD_RST;
    else
      rdata_r <= {rd_hi_w, rd_lo_w};
  end

  // oscillator pins are asynchronous: two flops, then edge detect
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      first_oscillator_sync_r <= 2'h0;
      second_oscillator_sync_r <= 2'h0;
      first_oscillator_prev_r <= 1'b0;
      second_oscillator_prev_r <= 1'b0;
    end
    else
    begin
      first_oscillator_sync_r <= {first_oscillator_sync_r[0], first_osc_i};
      second_oscillator_sync_r <= {second_oscillator_sync_r[0], second_osc_i};
      first_oscillator_prev_r <= first_oscillator_sync_r[1];
      second_oscillator_prev_r <= second_oscillator_sync_r[1];
    end
  end

  // oscillators only count if slower than half the core clock
  assign first_oscillator_edge_w = first_oscillator_sync_r[1] & ~first_oscillator_prev_r;
  assign second_oscillator_edge_w = second_oscillator_sync_r[1] & ~second_oscillator_prev_r;

  // prescaler source, period and match pulse
  assign pre_run_w    = ctrl_r[DTP_A_SEL] | ctrl_r[DTP_B_SEL];
  assign pre_src_w    = dtp_src_t'(clkset_r[DTP_SRC_MSB:DTP_SRC_LSB]);
  assign pre_period_w = clkset_r[DTP_PER_MSB:DTP_PER_LSB];
  assign pre_en_w     = (pre_src_w == DTP_SRC_SYS)
                      | ((pre_src_w == DTP_SRC_FIRST_OSCILLATOR) & first_oscillator_edge_w)
                      | ((pre_src_w == DTP_SRC_SECOND_OSCILLATOR) & second_oscillator_edge_w);
  assign pre_tick_w   = pre_run_w & pre_en_w
                      & (pre_cnt_r == pre_period_w);

  // prescaler counter: held at zero when no channel selects it
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !pre_run_w)
      pre_cnt_r <= PRE_ZERO;
    else if (pre_tick_w)
      pre_cnt_r <= PRE_ZERO;
    else if (pre_en_w)
      pre_cnt_r <= pre_cnt_r + PRE_ONE;
  end

  // channel controls; select bits are trusted to move only when stopped
  assign ch_a.run       = ctrl_r[DTP_A_RUN];
  assign ch_a.clk_sel   = ctrl_r[DTP_A_SEL];
  assign ch_a.pre_tick  = pre_tick_w;
  assign ch_a.match_val = {a_high_r, a_low_r};
  assign ch_b.run       = ctrl_r[DTP_B_RUN];
  assign ch_b.clk_sel   = ctrl_r[DTP_B_SEL];
  assign ch_b.pre_tick  = pre_tick_w;
  assign ch_b.match_val = {b_high_r, b_low_r};

  // two identical channels sharing only the prescaler pulse
  dtp_timer_chan #(.W(CNT_W)) u_chan_a (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ch         (ch_a.chan)
  );

  dtp_timer_chan #(.W(CNT_W)) u_chan_b (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ch         (ch_b.chan)
  );

  // interrupt requests from next-state flags so they track the flags
  assign flag_a_w = ctrl_nxt[DTP_A_FLG];
  assign flag_b_w = ctrl_nxt[DTP_B_FLG];
  assign pend_a_w = flag_a_w & ctrl_nxt[DTP_A_IE];
  assign pend_b_w = flag_b_w & ctrl_nxt[DTP_B_IE];

  // channel a wins the vector when both are pending
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
      irq_r   <= 1'b0;
      vec_r   <= DTP_VEC_NONE;
    end
    else
    begin
      irq_a_r <= pend_a_w;
      irq_b_r <= pend_b_w;
      irq_r   <= pend_a_w | pend_b_w;
      vec_r   <= pend_a_w ? DTP_VEC_A
               : (pend_b_w ? DTP_VEC_B : DTP_VEC_NONE);
    end
  end

  assign bus_rdata_o          = rdata_r;
  assign timer_a_toggle_out_o = ch_a.toggle;
  assign timer_b_toggle_out_o = ch_b.toggle;
  assign timer_a_irq_o        = irq_a_r;
  assign timer_b_irq_o        = irq_b_r;
  assign irq_o                = irq_r;
  assign irq_vector_o         = vec_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_flag_set: assert property (
    ch_a.match_pulse |=> ctrl_r[DTP_A_FLG])
    else $error("channel a flag not set on match");
  chk_flag_sticky: assert property (
    ctrl_r[DTP_B_FLG] && !we_ctrl_w && !we_iclr_w
    |=> ctrl_r[DTP_B_FLG])
    else $error("channel b flag dropped by hardware");
  chk_irq_level: assert property (
    irq_o == ((ctrl_r[DTP_A_FLG] & ctrl_r[DTP_A_IE])
            | (ctrl_r[DTP_B_FLG] & ctrl_r[DTP_B_IE])))
    else $error("interrupt output disagrees with flags");
  chk_vec_a: assert property (
    timer_a_irq_o |-> irq_vector_o == DTP_VEC_A)
    else $error("wrong vector for channel a");
  chk_pre_stop: assert property (
    !pre_run_w |=> pre_cnt_r == PRE_ZERO)
    else $error("prescaler not held when unused");
  chk_pre_inhib: assert property (
    pre_src_w == DTP_SRC_INHIB |-> !pre_tick_w)
    else $error("inhibited prescaler source produced a pulse");
  chk_pre_period: assert property (
    pre_tick_w ##1 (pre_run_w && pre_src_w == DTP_SRC_SYS
    && $stable(pre_period_w)) [*3] |-> pre_cnt_r == PRE_W'(2)
    || pre_period_w < PRE_W'(3))
    else $error("prescaler count off after match");
  chk_read_once: assert property (
    !bus_rd_i |=> bus_rdata_o == DTP_WORD_RST)
    else $error("read data present without a read");

  cov_irq_a: cover property (timer_a_irq_o);
  cov_pre_tick: cover property (pre_tick_w && ch_b.match_pulse);
  cov_word_wr: cover property (we_a_lo_w && we_a_hi_w);

endmodule

// *** hw/dtp_pkg.sv ***
package dtp_pkg;

  localparam int DTP_CNT_W = 16;
  localparam int DTP_PRE_W = 4;

  // register byte addresses
  localparam logic [15:0] DTP_ADDR_A_LOW  = 16'h7FA0;
  localparam logic [15:0] DTP_ADDR_A_HIGH = 16'h7FA1;
  localparam logic [15:0] DTP_ADDR_B_LOW  = 16'h7FA2;
  localparam logic [15:0] DTP_ADDR_B_HIGH = 16'h7FA3;
  localparam logic [15:0] DTP_ADDR_CTRL   = 16'h7FA4;
  localparam logic [15:0] DTP_ADDR_CLKSET = 16'h7FB6;
  localparam logic [15:0] DTP_ADDR_ISTAT  = 16'h7FC0;
  localparam logic [15:0] DTP_ADDR_ICLR   = 16'h7FC1;
  localparam logic [15:0] DTP_ADDR_IEN    = 16'h7FC2;
  localparam logic [15:0] DTP_ADDR_STEP   = 16'h0001;

  // control register fields
  localparam int DTP_B_RUN = 7;
  localparam int DTP_B_SEL = 6;
  localparam int DTP_B_FLG = 5;
  localparam int DTP_B_IE  = 4;
  localparam int DTP_A_RUN = 3;
  localparam int DTP_A_SEL = 2;
  localparam int DTP_A_FLG = 1;
  localparam int DTP_A_IE  = 0;

  // clock-setting register fields
  localparam int DTP_PER_MSB = 7;
  localparam int DTP_PER_LSB = 4;
  localparam int DTP_SRC_MSB = 3;
  localparam int DTP_SRC_LSB = 2;

  // interrupt status, clear and enable layout
  localparam int DTP_IRQ_A = 0;
  localparam int DTP_IRQ_B = 1;

  localparam logic [7:0]  DTP_BYTE_RST  = 8'h00;
  localparam logic [15:0] DTP_WORD_RST  = 16'h0000;
  localparam logic        DTP_OUT_IDLE  = 1'b1;
  localparam logic [15:0] DTP_VEC_A     = 16'h8024;
  localparam logic [15:0] DTP_VEC_B     = 16'h8030;
  localparam logic [15:0] DTP_VEC_NONE  = 16'h0000;

  typedef enum logic [1:0] {
    DTP_SRC_SYS   = 2'h0,
    DTP_SRC_INHIB = 2'h1,
    DTP_SRC_FIRST_OSCILLATOR  = 2'h2,
    DTP_SRC_SECOND_OSCILLATOR  = 2'h3
  } dtp_src_t;

endpackage

// *** hw/dtp_timer_chan.sv ***
`timescale 1ns/10ps
module dtp_timer_chan
  import dtp_pkg::*;
#(
  parameter int W = DTP_CNT_W
)
(
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  dtp_chan_if.chan  ch
);

  localparam logic [W-1:0] ONE  = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  logic [W-1:0] cnt_r;
  logic [W-1:0] buf_r;
  logic         tog_r;
  logic         cnt_en_w;
  logic         match_w;

  // count source: every clock or prescaler pulse
  assign cnt_en_w = ch.run
                  & (ch.clk_sel ? ch.pre_tick : 1'b1);
  assign match_w  = cnt_en_w & (cnt_r == buf_r);

  assign ch.match_pulse = match_w;
  assign ch.toggle      = tog_r;
  assign ch.count       = cnt_r;

  // counter: zero while stopped, wraps on match, so period is buf+1
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !ch.run)
      cnt_r <= ZERO;
    else if (match_w)
      cnt_r <= ZERO;
    else if (cnt_en_w)
      cnt_r <= cnt_r + ONE;
  end

  // match buffer: transparent when stopped, reloaded only on match
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      buf_r <= ZERO;
    else if (!ch.run)
      buf_r <= ch.match_val;
    else if (match_w)
      buf_r <= ch.match_val;
  end

  // toggle output: idle high, flips per match
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !ch.run)
      tog_r <= DTP_OUT_IDLE;
    else if (match_w)
      tog_r <= ~tog_r;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_stop_zero: assert property (!ch.run |=> cnt_r == ZERO)
    else $error("stopped counter not zero");
  chk_match_wrap: assert property (match_w |=> cnt_r == ZERO)
    else $error("counter did not restart on match");
  chk_count_step: assert property (
    cnt_en_w && !match_w |=> cnt_r == $past(cnt_r) + ONE)
    else $error("counter did not advance");
  chk_buf_follow: assert property (
    !ch.run |=> buf_r == $past(ch.match_val))
    else $error("stopped buffer not following");
  chk_buf_hold: assert property (
    ch.run && !match_w ##1 ch.run |-> $stable(buf_r))
    else $error("running buffer changed without match");
  chk_toggle_idle: assert property (!ch.run |=> tog_r)
    else $error("toggle output not high when stopped");
  chk_toggle_flip: assert property (
    ch.run && match_w ##1 ch.run |-> tog_r != $past(tog_r))
    else $error("toggle output did not flip on match");

  cov_match_wrap: cover property (match_w ##1 cnt_en_w);
  cov_toggle_two: cover property (match_w ##[1:40] match_w);

endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import dtp_pkg::*;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] d;
    logic        w;
    logic [15:0] e;
  } dtp_row_t;

  logic        clk;
  logic        rst;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        word;
  logic [15:0] rdata;
  logic [7:0]  osc_cnt = 8'h00;
  wire  logic  first_oscillator = osc_cnt[3];
  wire  logic  second_oscillator = osc_cnt[2];
  logic        tog_a;
  logic        tog_b;
  logic        irq_a;
  logic        irq_b;
  logic        irq;
  logic [15:0] vec;
  logic [15:0] got;
  int          n_errors;
  int          checks_done;
  int          n;
  dtp_row_t    rows [12];

  dtp_dual_timer u_dut (
    .core_clk_i           (clk),
    .sys_rst_i            (rst),
    .bus_addr_i           (addr),
    .bus_wdata_i          (wdata),
    .bus_wr_i             (wr),
    .bus_rd_i             (rd),
    .bus_word_i           (word),
    .bus_rdata_o          (rdata),
    .first_osc_i          (first_oscillator),
    .second_osc_i         (second_oscillator),
    .timer_a_toggle_out_o (tog_a),
    .timer_b_toggle_out_o (tog_b),
    .timer_a_irq_o        (irq_a),
    .timer_b_irq_o        (irq_b),
    .irq_o                (irq),
    .irq_vector_o         (vec)
  );

  // core clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // oscillator pins: first one 16 cycles, second one 8 cycles
  always @(posedge clk)
    osc_cnt <= osc_cnt + 8'h01;

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // one-cycle write strobe; next access waits a further edge
  task automatic bw(input logic [15:0] a, input logic [15:0] d,
                    input logic w);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    word  <= w;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample there
  task automatic br(input logic [15:0] a, input logic w);
    @(posedge clk);
    addr <= a;
    word <= w;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    got = rdata;
  endtask

  // cycles until the chosen toggle output next changes, bounded
  task automatic wait_tg(input logic b, output int cnt);
    logic t0;
    t0  = b ? tog_b : tog_a;
    cnt = 0;
    while ((b ? tog_b : tog_a) === t0 && cnt < 400)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= 400)
    begin
      $display("CHECK FAILED toggle edge expected 1 seen 0");
      n_errors++;
      final_report;
    end
  endtask

  task automatic half(input logic b, input logic [15:0] e);
    wait_tg(b, n);
    wait_tg(b, n);
    chk("toggle half period", e, 16'(n));
  endtask

  initial
  begin
    rst   = 1'b1;
    addr  = 16'h0000;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
    word  = 1'b0;
    n_errors    = 0;
    checks_done = 0;
    rows = '{'{16'h7FA0, 16'h005A, 1'b0, 16'h005A},
             '{16'h7FA1, 16'h00A5, 1'b0, 16'h00A5},
             '{16'h7FA2, 16'h003C, 1'b0, 16'h003C},
             '{16'h7FA3, 16'h00C3, 1'b0, 16'h00C3},
             '{16'h7FA0, 16'h1234, 1'b1, 16'h1234},
             '{16'h7FA2, 16'hABCD, 1'b1, 16'hABCD},
             '{16'h7FA1, 16'h00EE, 1'b0, 16'h00EE},
             '{16'h7FB6, 16'h00F3, 1'b0, 16'h00F3},
             '{16'h7FA4, 16'h0033, 1'b0, 16'h0011},
             '{16'h7FC2, 16'h0002, 1'b0, 16'h0002},
             '{16'h7F00, 16'h00FF, 1'b0, 16'h0000},
             '{16'h7FC1, 16'h0003, 1'b0, 16'h0000}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values of the mapped registers and outputs
    for (int i = 0; i < 5; i++)
    begin
      br(DTP_ADDR_A_LOW + 16'(i), 1'b0);
      chk("reset register", 16'h0000, got);
    end
    br(DTP_ADDR_CLKSET, 1'b0);
    chk("reset clock setting", 16'h0000, got);
    chk("idle toggle a", 16'h0001, {15'h0000, tog_a});
    chk("idle toggle b", 16'h0001, {15'h0000, tog_b});
    chk("idle vector", 16'h0000, vec);
    $display("test reset done");
    // ordinary accesses: write then read back; flags cannot be set
    foreach (rows[i])
    begin
      bw(rows[i].a, rows[i].d, rows[i].w);
      br(rows[i].a, rows[i].w);
      chk("register readback", rows[i].e, got);
    end
    br(DTP_ADDR_CTRL, 1'b0);
    chk("enable alias", 16'h0010, got);
    br(DTP_ADDR_A_LOW, 1'b1);
    chk("word pairing", 16'hEE34, got);
    bw(DTP_ADDR_CTRL, 16'h0000, 1'b0);
    bw(DTP_ADDR_CLKSET, 16'h0000, 1'b0);
    $display("test registers done");
    // channel a on system clock, then a reload while running
    bw(DTP_ADDR_A_LOW, 16'h0003, 1'b1);
    bw(DTP_ADDR_CTRL, 16'h0009, 1'b0);
    half(1'b0, 16'h0004);
    chk("irq a", 16'h0001, {15'h0000, irq_a});
    chk("irq b", 16'h0000, {15'h0000, irq_b});
    chk("irq any", 16'h0001, {15'h0000, irq});
    chk("vector a", DTP_VEC_A, vec);
    // write lands two edges into the old period; a buffer taken at
    // once would stretch the remainder from 2 to 4 cycles
    bw(DTP_ADDR_A_LOW, 16'h0005, 1'b1);
    wait_tg(1'b0, n);
    chk("old match kept", 16'h0002, 16'(n));
    wait_tg(1'b0, n);
    chk("new match used", 16'h0006, 16'(n));
    br(DTP_ADDR_CTRL, 1'b0);
    chk("control running", 16'h000B, got);
    bw(DTP_ADDR_CTRL, 16'h0003, 1'b0);
    br(DTP_ADDR_CTRL, 1'b0);
    chk("flag kept", 16'h0003, got);
    chk("stopped toggle", 16'h0001, {15'h0000, tog_a});
    br(DTP_ADDR_ISTAT, 1'b0);
    chk("status", 16'h0001, got);
    bw(DTP_ADDR_ICLR, 16'h0001, 1'b0);
    br(DTP_ADDR_ISTAT, 1'b0);
    chk("status cleared", 16'h0000, got);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    chk("vector none", DTP_VEC_NONE, vec);
    $display("test channel a done");
    // channel b from prescaler: period 3 clocks, match 1; match bytes
    // only written while stopped, select set before run
    bw(DTP_ADDR_B_LOW, 16'h0001, 1'b1);
    bw(DTP_ADDR_CLKSET, 16'h0023, 1'b0);
    bw(DTP_ADDR_CTRL, 16'h0050, 1'b0);
    bw(DTP_ADDR_CTRL, 16'h00D0, 1'b0);
    half(1'b1, 16'h0006);
    chk("a untouched", 16'h0001, {15'h0000, tog_a});
    chk("vector b", DTP_VEC_B, vec);
    bw(DTP_ADDR_CTRL, 16'h0070, 1'b0);
    bw(DTP_ADDR_CTRL, 16'h0050, 1'b0);
    br(DTP_ADDR_CTRL, 1'b0);
    chk("flag b cleared", 16'h0050, got);
    chk("irq b low", 16'h0000, {15'h0000, irq_b});
    bw(DTP_ADDR_CTRL, 16'h0000, 1'b0);
    $display("test channel b done");
    // prescaler sources: first and second oscillator, then inhibited
    bw(DTP_ADDR_CTRL, 16'h0004, 1'b0);
    bw(DTP_ADDR_A_LOW, 16'h0001, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      bw(DTP_ADDR_CLKSET, k ? 16'h000C : 16'h0008, 1'b0);
      bw(DTP_ADDR_CTRL, 16'h000C, 1'b0);
      half(1'b0, k ? 16'h0010 : 16'h0020);
      bw(DTP_ADDR_CTRL, 16'h0004, 1'b0);
    end
    bw(DTP_ADDR_CLKSET, 16'h0004, 1'b0);
    bw(DTP_ADDR_CTRL, 16'h000C, 1'b0);
    repeat (100) @(posedge clk);
    #1;
    chk("inhibited source", 16'h0001, {15'h0000, tog_a});
    bw(DTP_ADDR_CTRL, 16'h0004, 1'b0);
    bw(DTP_ADDR_CTRL, 16'h0000, 1'b0);
    $display("test sources done");
    // reset in mid-run returns everything to idle
    bw(DTP_ADDR_CLKSET, 16'h0000, 1'b0);
    bw(DTP_ADDR_CTRL, 16'h0008, 1'b0);
    repeat (7) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    br(DTP_ADDR_CTRL, 1'b0);
    chk("control after reset", 16'h0000, got);
    chk("toggle after reset", 16'h0001, {15'h0000, tog_a});
    $display("test mid reset done");
    final_report;
  end
endmodule
